/* bench/rvs_regs_tb.sv */
// Self-checking bench for the rail voltage and sleep register bank
`timescale 1ns/1ps
`default_nettype none
module rvs_regs_tb;
    import rvs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    // Factory image: volt bit 0 set, ctrl4 bits 7:6 set to prove they read 0
    rvs_otp_s otp = {8'h40, 8'h41, 8'h20, 8'hCF, 1'b1, 1'b0};
    rvs_bus_s bus = '0;
    logic first_sleep_pin = 1'b1;
    logic second_sleep_pin = 1'b1;
    logic [7:0] reg_rdata_q;
    logic regs_loaded_q;
    logic [6:0] target;
    logic decay_sel;
    logic in_sleep;
    logic use_sleep4;
    logic mode4;
    logic on4;
    int err_count = 0;
    int num_checks = 0;
    logic [1:0] sel4;

    always #4 clk = ~clk;

    rvs_regs DUT (.clk(clk), .rst_n(rst_n), .otp(otp), .bus(bus), .first_sleep_pin(first_sleep_pin),
        .second_sleep_pin(second_sleep_pin), .reg_rdata_q(reg_rdata_q), .regs_loaded_q(regs_loaded_q),
        .third_rail_target_code_q(target), .third_rail_decay_select_q(decay_sel),
        .third_rail_in_sleep_q(in_sleep), .fourth_rail_use_sleep_code_q(use_sleep4),
        .fourth_rail_operating_mode_q(mode4), .fourth_rail_on_control_q(on4));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 bus = '{wr: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        #1 bus.wr = 1'b0;
    endtask

    // Read data is registered: valid one edge after the address is shown
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge clk);
        #1 bus.addr = a;
        @(posedge clk);
        #1 check(name, reg_rdata_q, exp);
    endtask

    // Pins pass two sync flops, so allow a margin past the three-edge latency
    task automatic settle;
        repeat (5) @(posedge clk);
        #1;
    endtask

    task automatic results;
        $display("Checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        #(5000 * 8);
        err_count++;
        results();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        #1 check("rdata_in_rst", reg_rdata_q, 8'h00);
        check("loaded_in_rst", {7'h00, regs_loaded_q}, 8'h00);
        check("on_in_rst", {7'h00, on4}, 8'h00);
        rst_n = 1'b1;
        repeat (2) @(posedge clk);
        #1 check("loaded", {7'h00, regs_loaded_q}, 8'h01);
        rd(RVS_OFF_DECAY, 8'h40, "decay_rst");
        rd(RVS_OFF_VOLT, 8'h41, "volt_rst");
        rd(RVS_OFF_SLEEP, 8'h20, "sleep_rst");
        rd(RVS_OFF_CTRL4, 8'h0F, "ctrl4_rst");
        check("target_rst", {1'b0, target}, 8'h20);
        check("mode_rst", {7'h00, mode4}, 8'h01);
        check("on_rst", {7'h00, on4}, 8'h01);
        $display("Test reset values done");

        wr(RVS_OFF_DECAY, 8'hAB);
        rd(RVS_OFF_DECAY, 8'hAB, "decay_rw");
        check("decay_sel_1", {7'h00, decay_sel}, 8'h01);
        check("target_spare", {1'b0, target}, 8'h20);
        wr(RVS_OFF_DECAY, 8'hAA);
        settle();
        check("decay_sel_0", {7'h00, decay_sel}, 8'h00);
        wr(RVS_OFF_VOLT, 8'h54);
        rd(RVS_OFF_VOLT, 8'h55, "volt_bit0");
        check("target_new", {1'b0, target}, 8'h2A);
        wr(RVS_OFF_CTRL4, 8'hFC);
        rd(RVS_OFF_CTRL4, 8'h3C, "ctrl4_ro");
        check("mode_auto", {7'h00, mode4}, 8'h00);
        check("on_off", {7'h00, on4}, 8'h00);
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h00, "unmapped");
        $display("Test register access done");

        wr(RVS_OFF_SLEEP, 8'h66);
        second_sleep_pin = 1'b0;
        settle();
        check("target_slp_off", {1'b0, target}, 8'h2A);
        check("in_sleep_off", {7'h00, in_sleep}, 8'h00);
        wr(RVS_OFF_SLEEP, 8'h67);
        settle();
        check("target_slp", {1'b0, target}, 8'h33);
        check("in_sleep_on", {7'h00, in_sleep}, 8'h01);
        second_sleep_pin = 1'b1;
        first_sleep_pin = 1'b0;
        settle();
        check("target_pin_hi", {1'b0, target}, 8'h2A);
        check("wrong_pin", {7'h00, in_sleep}, 8'h00);
        $display("Test third rail sleep done");

        // Software may only write the legal encodings 00 and 11
        for (int v = 0; v < 4; v += 3)
        begin
            sel4 = 2'(v);
            wr(RVS_OFF_CTRL4, {2'b00, sel4, 2'b11, 2'b11});
            settle();
            check("use_sleep4", {7'h00, use_sleep4}, {7'h00, sel4 == RVS_SLP4_ON});
        end
        first_sleep_pin = 1'b1;
        settle();
        check("use_sleep4_hi", {7'h00, use_sleep4}, 8'h00);
        check("mode_pwm", {7'h00, mode4}, 8'h01);
        check("on_en", {7'h00, on4}, 8'h01);
        $display("Test fourth rail done");

        // Mid-run reset reloads factory values; a write at the load edge is refused
        @(posedge clk);
        #1 rst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1 check("target_in_rst", {1'b0, target}, 8'h00);
        check("mode_in_rst", {7'h00, mode4}, 8'h00);
        rst_n = 1'b1;
        bus = '{wr: 1'b1, addr: RVS_OFF_VOLT, wdata: 8'h00};
        @(posedge clk);
        #1 bus.wr = 1'b0;
        check("loaded_again", {7'h00, regs_loaded_q}, 8'h01);
        rd(RVS_OFF_VOLT, 8'h41, "volt_reload");
        rd(RVS_OFF_CTRL4, 8'h0F, "ctrl4_reload");
        rd(RVS_OFF_SLEEP, 8'h20, "sleep_reload");
        rd(RVS_OFF_DECAY, 8'h40, "decay_reload");
        check("target_reload", {1'b0, target}, 8'h20);
        $display("Test mid-run reset done");
        results();
    end
endmodule
`default_nettype wire

/* verilog/rvs_pkg.sv */
// Package for the rail voltage and sleep register bank
package rvs_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] RVS_OFF_DECAY = 8'h22;
    localparam logic [7:0] RVS_OFF_VOLT = 8'h23;
    localparam logic [7:0] RVS_OFF_SLEEP = 8'h24;
    localparam logic [7:0] RVS_OFF_CTRL4 = 8'h25;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int RVS_CODE_MSB = 7;
    localparam int RVS_CODE_LSB = 1;
    localparam int RVS_BIT0 = 0;
    localparam int RVS_C4_RO_MSB = 7;
    localparam int RVS_C4_RO_LSB = 6;
    localparam int RVS_C4_SLP_MSB = 5;
    localparam int RVS_C4_SLP_LSB = 4;
    localparam int RVS_C4_RSV_MSB = 3;
    localparam int RVS_C4_RSV_LSB = 2;
    localparam int RVS_C4_MODE = 1;
    localparam int RVS_C4_ON = 0;

    // ----------------------------------------------------------------
    // Values and reset state
    // ----------------------------------------------------------------
    localparam logic [1:0] RVS_SLP4_ON = 2'h3;
    localparam logic [1:0] RVS_C4_RO_VAL = 2'h0;
    localparam logic [7:0] RVS_BYTE_RST = 8'h00;
    localparam logic [6:0] RVS_CODE_RST = 7'h00;
    // Sync flops start at the idle high pin level so no false sleep follows reset
    localparam logic [1:0] RVS_SYNC_RST = 2'h3;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] decay;
        logic [7:0] volt;
        logic [7:0] sleep;
        logic [7:0] ctrl4;
        logic third_pin_sel;
        logic fourth_pin_sel;
    } rvs_otp_s;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rvs_bus_s;

endpackage

/* verilog/rvs_regs.sv */
// Rail voltage, sleep and fourth-rail control register bank
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Decay bit: 0 slews down, 1 decays
// - Decay bits 7:1 spare, stored, no effect
// - Voltage bits 7:1 set normal target code
// - Sleep bits 7:1 set sleep target code
// - Sleep pin choice fixed at factory load
// - Sleep enable 0 always uses normal code
// - Enabled: pin low sleep, high normal
// - Fourth-rail register fields and read-only bits
// - Reset values loaded from factory settings
// - Fourth sleep 11 enables, others normal
// - Mode bit: 0 automatic, 1 forced PWM
// - On bit 0 forces rail off
module rvs_regs
(
    input wire logic clk,
    input wire logic rst_n,
    input wire rvs_pkg::rvs_otp_s otp,
    input wire rvs_pkg::rvs_bus_s bus,
    input wire logic first_sleep_pin,
    input wire logic second_sleep_pin,
    output logic [7:0] reg_rdata_q,
    output logic regs_loaded_q,
    output logic [6:0] third_rail_target_code_q,
    output logic third_rail_decay_select_q,
    output logic third_rail_in_sleep_q,
    output logic fourth_rail_use_sleep_code_q,
    output logic fourth_rail_operating_mode_q,
    output logic fourth_rail_on_control_q
);
    import rvs_pkg::*;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0] decay_q;
    logic [7:0] volt_q;
    logic [7:0] sleep_q;
    logic [5:0] ctrl4_q;
    logic third_sel_q;
    logic fourth_sel_q;
    logic [1:0] pin_s1_q;
    logic [1:0] pin_s2_q;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire logic wr_ok = bus.wr && regs_loaded_q;
    wire logic wr_decay = wr_ok && (bus.addr == RVS_OFF_DECAY);
    wire logic wr_volt = wr_ok && (bus.addr == RVS_OFF_VOLT);
    wire logic wr_sleep = wr_ok && (bus.addr == RVS_OFF_SLEEP);
    wire logic wr_ctrl4 = wr_ok && (bus.addr == RVS_OFF_CTRL4);
    wire logic [7:0] ctrl4_view = {RVS_C4_RO_VAL, ctrl4_q};
    // Unmapped offsets read as zero
    wire logic [7:0] rdata_d = (bus.addr == RVS_OFF_DECAY) ? decay_q :
                               (bus.addr == RVS_OFF_VOLT) ? volt_q :
                               (bus.addr == RVS_OFF_SLEEP) ? sleep_q :
                               (bus.addr == RVS_OFF_CTRL4) ? ctrl4_view : RVS_BYTE_RST;

    // ----------------------------------------------------------------
    // Target selection
    // ----------------------------------------------------------------
    // Only the second synchroniser stage feeds the select
    wire logic third_pin = third_sel_q ? pin_s2_q[1] : pin_s2_q[0];
    wire logic fourth_pin = fourth_sel_q ? pin_s2_q[1] : pin_s2_q[0];
    // Sleep only when enabled and pin low
    wire logic third_sleep_d = sleep_q[RVS_BIT0] && !third_pin;
    wire logic fourth_sleep_d = (ctrl4_q[RVS_C4_SLP_MSB:RVS_C4_SLP_LSB] == RVS_SLP4_ON) && !fourth_pin;
    // Normal or sleep code to the regulator
    wire logic [6:0] target_d = third_sleep_d ? sleep_q[RVS_CODE_MSB:RVS_CODE_LSB]
                                              : volt_q[RVS_CODE_MSB:RVS_CODE_LSB];

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Idle high at reset: a low start would fake a sleep request
            pin_s1_q <= RVS_SYNC_RST;
            pin_s2_q <= RVS_SYNC_RST;
        end
        else
        begin
            pin_s1_q <= {second_sleep_pin, first_sleep_pin};
            pin_s2_q <= pin_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // Factory load and register writes
    // ----------------------------------------------------------------
    // Factory values cannot enter the async reset; they load on the first edge after release
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            regs_loaded_q <= 1'b0;
            decay_q <= RVS_BYTE_RST;
            volt_q <= RVS_BYTE_RST;
            sleep_q <= RVS_BYTE_RST;
            ctrl4_q <= RVS_BYTE_RST[5:0];
            third_sel_q <= 1'b0;
            fourth_sel_q <= 1'b0;
        end
        else if (!regs_loaded_q)
        begin
            regs_loaded_q <= 1'b1;
            decay_q <= otp.decay;
            volt_q <= otp.volt;
            sleep_q <= otp.sleep;
            ctrl4_q <= otp.ctrl4[5:0];
            third_sel_q <= otp.third_pin_sel;
            fourth_sel_q <= otp.fourth_pin_sel;
        end
        else
        begin
            if (wr_decay)
                decay_q <= bus.wdata;
            // Bit 0 keeps its factory value
            if (wr_volt)
                volt_q[RVS_CODE_MSB:RVS_CODE_LSB] <= bus.wdata[RVS_CODE_MSB:RVS_CODE_LSB];
            if (wr_sleep)
                sleep_q <= bus.wdata;
            // Bits 7:6 not stored; bits 3:2 stored as written
            if (wr_ctrl4)
                ctrl4_q <= bus.wdata[5:0];
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata_q <= RVS_BYTE_RST;
            third_rail_target_code_q <= RVS_CODE_RST;
            third_rail_decay_select_q <= 1'b0;
            third_rail_in_sleep_q <= 1'b0;
            fourth_rail_use_sleep_code_q <= 1'b0;
            fourth_rail_operating_mode_q <= 1'b0;
            fourth_rail_on_control_q <= 1'b0;
        end
        else
        begin
            reg_rdata_q <= rdata_d;
            third_rail_target_code_q <= target_d;
            // Decay select straight from bit 0
            third_rail_decay_select_q <= decay_q[RVS_BIT0];
            third_rail_in_sleep_q <= third_sleep_d;
            fourth_rail_use_sleep_code_q <= fourth_sleep_d;
            fourth_rail_operating_mode_q <= ctrl4_q[RVS_C4_MODE];
            fourth_rail_on_control_q <= ctrl4_q[RVS_C4_ON] && regs_loaded_q;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking rvs_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_decay_select_out: assert property (
        regs_loaded_q |=> third_rail_decay_select_q == $past(decay_q[RVS_BIT0]))
        else $error("decay select does not follow register bit");

    a_spare_write_kept: assert property (
        wr_decay |=> decay_q[RVS_CODE_MSB:RVS_CODE_LSB] == $past(bus.wdata[RVS_CODE_MSB:RVS_CODE_LSB])
                     ##1 reg_rdata_q[RVS_CODE_MSB:RVS_CODE_LSB] == $past(decay_q[RVS_CODE_MSB:RVS_CODE_LSB]) || $past(bus.addr) != RVS_OFF_DECAY)
        else $error("spare field not stored or read back");

    a_normal_code_write: assert property (
        wr_volt |=> volt_q[RVS_CODE_MSB:RVS_CODE_LSB] == $past(bus.wdata[RVS_CODE_MSB:RVS_CODE_LSB]))
        else $error("normal code write lost");

    a_sleep_code_used: assert property (
        regs_loaded_q && sleep_q[RVS_BIT0] && !third_pin
        |=> third_rail_target_code_q == $past(sleep_q[RVS_CODE_MSB:RVS_CODE_LSB]) && third_rail_in_sleep_q)
        else $error("sleep code not selected");

    a_pin_choice_fixed: assert property (
        regs_loaded_q |=> $stable(third_sel_q) && $stable(fourth_sel_q))
        else $error("sleep pin choice changed");

    a_sleep_off_normal: assert property (
        regs_loaded_q && !sleep_q[RVS_BIT0]
        |=> third_rail_target_code_q == $past(volt_q[RVS_CODE_MSB:RVS_CODE_LSB]) && !third_rail_in_sleep_q)
        else $error("normal code not used with sleep disabled");

    a_pin_high_normal: assert property (
        regs_loaded_q && sleep_q[RVS_BIT0] && third_pin
        |=> third_rail_target_code_q == $past(volt_q[RVS_CODE_MSB:RVS_CODE_LSB]))
        else $error("normal code not used with pin high");

    a_ctrl4_ro_zero: assert property (
        bus.addr == RVS_OFF_CTRL4 |=> reg_rdata_q[RVS_C4_RO_MSB:RVS_C4_RO_LSB] == RVS_C4_RO_VAL)
        else $error("fourth-rail read-only bits not zero");

    a_factory_load: assert property (
        !regs_loaded_q |=> regs_loaded_q && volt_q == $past(otp.volt) && sleep_q == $past(otp.sleep)
                           && decay_q == $past(otp.decay) && ctrl4_q == $past(otp.ctrl4[5:0]))
        else $error("factory values not loaded");

    a_fourth_sleep_enc: assert property (
        ctrl4_q[RVS_C4_SLP_MSB:RVS_C4_SLP_LSB] != RVS_SLP4_ON |=> !fourth_rail_use_sleep_code_q)
        else $error("reserved sleep encoding enabled sleep");

    a_mode_follows: assert property (
        wr_ctrl4 |=> ##1 fourth_rail_operating_mode_q == $past(bus.wdata[RVS_C4_MODE], 2))
        else $error("mode output does not follow write");

    a_off_forces_off: assert property (
        !ctrl4_q[RVS_C4_ON] |=> !fourth_rail_on_control_q)
        else $error("rail on while on bit is zero");

    a_volt_bit0_ro: assert property (
        regs_loaded_q |=> $stable(volt_q[RVS_BIT0]))
        else $error("voltage bit 0 changed");

    a_on_follows_bit: assert property (
        regs_loaded_q && ctrl4_q[RVS_C4_ON] |=> fourth_rail_on_control_q)
        else $error("rail off while on bit is one");

    a_fourth_sleep_sel: assert property (
        ctrl4_q[RVS_C4_SLP_MSB:RVS_C4_SLP_LSB] == RVS_SLP4_ON && !fourth_pin
        |=> fourth_rail_use_sleep_code_q)
        else $error("fourth rail sleep not selected");

    a_fourth_pin_high: assert property (
        fourth_pin |=> !fourth_rail_use_sleep_code_q)
        else $error("fourth rail sleep with pin high");

    a_ctrl4_write: assert property (
        wr_ctrl4 |=> ctrl4_q == $past(bus.wdata[5:0]))
        else $error("fourth-rail control write lost");

    a_sleep_write: assert property (
        wr_sleep |=> sleep_q == $past(bus.wdata))
        else $error("sleep register write lost");

    a_decay_bit_write: assert property (
        wr_decay |=> decay_q[RVS_BIT0] == $past(bus.wdata[RVS_BIT0]))
        else $error("decay select write lost");

    // Reads are registered: data appears one edge after the address
    a_volt_read_back: assert property (
        bus.addr == RVS_OFF_VOLT |=> reg_rdata_q == $past(volt_q))
        else $error("voltage register read mismatch");

    a_sleep_read_back: assert property (
        bus.addr == RVS_OFF_SLEEP |=> reg_rdata_q == $past(sleep_q))
        else $error("sleep register read mismatch");

    a_decay_read_back: assert property (
        bus.addr == RVS_OFF_DECAY |=> reg_rdata_q == $past(decay_q))
        else $error("decay register read mismatch");

    a_ctrl4_read_back: assert property (
        bus.addr == RVS_OFF_CTRL4 |=> reg_rdata_q[5:0] == $past(ctrl4_q))
        else $error("fourth-rail register read mismatch");

    a_loaded_stays: assert property (
        regs_loaded_q |=> regs_loaded_q)
        else $error("factory load flag dropped");

    a_write_before_load: assert property (
        !regs_loaded_q && bus.wr |=> volt_q == $past(otp.volt))
        else $error("write taken before factory load");

    a_pin_high_awake: assert property (
        regs_loaded_q && third_pin |=> !third_rail_in_sleep_q)
        else $error("sleep flag set with pin high");

    // ----------------------------------------------------------------
    // Cover points
    // ----------------------------------------------------------------
    c_enter_sleep: cover property (
        regs_loaded_q && sleep_q[RVS_BIT0] ##1 !third_rail_in_sleep_q ##1 third_rail_in_sleep_q);

    c_fourth_sleep: cover property (fourth_rail_use_sleep_code_q);

    c_rail_off_by_write: cover property (fourth_rail_on_control_q ##1 wr_ctrl4 && !bus.wdata[RVS_C4_ON]);

    c_fourth_pwm: cover property (wr_ctrl4 && bus.wdata[RVS_C4_MODE]);

    c_leave_sleep: cover property (third_rail_in_sleep_q ##1 !third_rail_in_sleep_q);

endmodule

`default_nettype wire
